//--- src/touch_adc_pkg.sv
// Shared constants and types of the touch screen converter control block
package touch_adc_pkg;

	// ----------------------------------------------------------------
	// Serial frame timing, counted in serial clock rising edges
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_BITS = 4'h7; // Command bits after the start bit
	localparam logic [3:0] ACQ_LEN = 4'h3; // Acquisition clocks after the command
	localparam logic [3:0] RES_FULL = 4'hC; // Decisions in 12-bit mode
	localparam logic [3:0] RES_SHORT = 4'h8; // Decisions in 8-bit mode

	// ----------------------------------------------------------------
	// Command byte field positions (after the start bit)
	// ----------------------------------------------------------------
	localparam int CMD_SEL_MSB = 6; // Channel selector, bit 2
	localparam int CMD_SEL_LSB = 4; // Channel selector, bit 0
	localparam int CMD_MODE8 = 3; // High selects 8-bit conversion
	localparam int CMD_SER = 2; // High selects single-ended reference
	localparam int CMD_PD1 = 1; // Reference power bit
	localparam int CMD_PD0 = 0; // Converter power bit

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] CMD_RST = 7'h00; // All off, differential, 12-bit
	localparam logic [11:0] CODE_RST = 12'h000; // Cleared code
	localparam logic [11:0] SAR_MSB = 12'h800; // First trial value
	localparam logic REF_ON_RST = 1'b0; // Internal reference off

	// ----------------------------------------------------------------
	// Channel selector values
	// ----------------------------------------------------------------
	localparam logic [2:0] SEL_TEMP_LO = 3'h0;
	localparam logic [2:0] SEL_Y_POS = 3'h1;
	localparam logic [2:0] SEL_BATTERY = 3'h2;
	localparam logic [2:0] SEL_Z1 = 3'h3;
	localparam logic [2:0] SEL_Z2 = 3'h4;
	localparam logic [2:0] SEL_X_POS = 3'h5;
	localparam logic [2:0] SEL_AUX = 3'h6;
	localparam logic [2:0] SEL_TEMP_HI = 3'h7;

	// ----------------------------------------------------------------
	// Positive converter input and reference source codes
	// ----------------------------------------------------------------
	localparam logic [2:0] IN_TEMP = 3'h0;
	localparam logic [2:0] IN_XP = 3'h1;
	localparam logic [2:0] IN_BAT = 3'h2;
	localparam logic [2:0] IN_YN = 3'h3;
	localparam logic [2:0] IN_YP = 3'h4;
	localparam logic [2:0] IN_AUX = 3'h5;
	localparam logic [2:0] REF_VREF = 3'h0;
	localparam logic [2:0] REF_GND = 3'h1;
	localparam logic [2:0] REF_YP = 3'h2;
	localparam logic [2:0] REF_YN = 3'h3;
	localparam logic [2:0] REF_XP = 3'h4;
	localparam logic [2:0] REF_XN = 3'h5;

	// Frame controller states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ACQ = 3'b010,
		ST_CONV = 3'b011,
		ST_TAIL = 3'b100
	} frame_state_e;

endpackage

//--- src/mux_route_decode.sv
// Channel selector decode into panel drivers, input mux and reference routing
`timescale 1ns/1ns
`default_nettype none

module mux_route_decode (
	input wire logic [2:0] sel,
	input wire logic single_ended,
	input wire logic drv_en,
	input wire logic acq,
	output logic xp_on,
	output logic xm_on,
	output logic yp_on,
	output logic ym_on,
	output logic [2:0] mux_in,
	output logic [2:0] ref_pos,
	output logic [2:0] ref_neg,
	output logic diode_lo,
	output logic diode_hi,
	output logic bat_div
);

	// ----------------------------------------------------------------
	// Routing table
	// ----------------------------------------------------------------
	// Drivers follow drv_en, bias loads follow acq only
	always_comb begin
		xp_on = 1'b0;
		xm_on = 1'b0;
		yp_on = 1'b0;
		ym_on = 1'b0;
		mux_in = touch_adc_pkg::IN_AUX;
		ref_pos = touch_adc_pkg::REF_VREF;
		ref_neg = touch_adc_pkg::REF_GND;
		diode_lo = 1'b0;
		diode_hi = 1'b0;
		bat_div = 1'b0;
		case (sel)
			touch_adc_pkg::SEL_TEMP_LO: begin
				mux_in = touch_adc_pkg::IN_TEMP;
				diode_lo = acq;
			end
			touch_adc_pkg::SEL_Y_POS: begin
				mux_in = touch_adc_pkg::IN_XP;
				yp_on = drv_en;
				ym_on = drv_en;
				if (!single_ended) begin
					ref_pos = touch_adc_pkg::REF_YP;
					ref_neg = touch_adc_pkg::REF_YN;
				end
			end
			touch_adc_pkg::SEL_BATTERY: begin
				mux_in = touch_adc_pkg::IN_BAT;
				bat_div = acq; // Divider draws current, so only while sampling
			end
			touch_adc_pkg::SEL_Z1, touch_adc_pkg::SEL_Z2: begin
				mux_in = (sel == touch_adc_pkg::SEL_Z1) ? touch_adc_pkg::IN_XP : touch_adc_pkg::IN_YN;
				xm_on = drv_en;
				yp_on = drv_en;
				if (!single_ended) begin
					ref_pos = touch_adc_pkg::REF_YP;
					ref_neg = touch_adc_pkg::REF_XN;
				end
			end
			touch_adc_pkg::SEL_X_POS: begin
				mux_in = touch_adc_pkg::IN_YP;
				xp_on = drv_en;
				xm_on = drv_en;
				if (!single_ended) begin
					ref_pos = touch_adc_pkg::REF_XP;
					ref_neg = touch_adc_pkg::REF_XN;
				end
			end
			touch_adc_pkg::SEL_AUX: begin
				mux_in = touch_adc_pkg::IN_AUX;
			end
			touch_adc_pkg::SEL_TEMP_HI: begin
				mux_in = touch_adc_pkg::IN_TEMP;
				diode_hi = acq;
			end
			default: begin
				mux_in = touch_adc_pkg::IN_AUX;
			end
		endcase
	end

endmodule

`default_nettype wire

//--- src/touch_adc_ctrl.sv
// Serial command, conversion sequencing and routing control of the touch converter
//
// Contract
// - Serial output changes on clock falling edges
// - Chip select high floats data and busy
// - Input bit captured on rising edge, select low
// - Select high powers converter down
// - Host serial clock steps whole conversion
// - Selector and reference mode come serially
// - Single-ended temp, battery, aux: drivers off
// - Single-ended position and pressure driver settings
// - Differential mode references from driven pins
// - Reference power bit switches internal reference
// - Straight binary code, span over 4096
// - Eight-clock exchanges, 24 clocks per conversion
// - Diode bias only during acquisition
// - Converter power bit keeps drivers on
`timescale 1ns/1ns
`default_nettype none

module touch_adc_ctrl (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic conv_serial_clock,
	input wire logic chip_sel_n,
	input wire logic serial_in,
	input wire logic cmp_high,
	output logic serial_out,
	output logic serial_out_oe,
	output logic conv_busy,
	output logic conv_busy_oe,
	output logic xp_drv_on,
	output logic xm_drv_on,
	output logic yp_drv_on,
	output logic ym_drv_on,
	output logic [2:0] mux_in_sel,
	output logic [2:0] ref_pos_sel,
	output logic [2:0] ref_neg_sel,
	output logic ref_mode_single_ended,
	output logic internal_ref_on,
	output logic adc_powered,
	output logic sample_hold,
	output logic diode_low_current,
	output logic diode_high_current,
	output logic battery_divider_on,
	output logic [11:0] dac_trial,
	output logic [11:0] result_code,
	output logic result_valid
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Number of decisions for the latched resolution bit
	function automatic logic [3:0] res_len(input logic mode8);
		res_len = mode8 ? touch_adc_pkg::RES_SHORT : touch_adc_pkg::RES_FULL;
	endfunction

	// ----------------------------------------------------------------
	// Serial clock edge detection
	// ----------------------------------------------------------------
	logic conv_serial_clock_q; // Last sample of the host serial clock
	logic conv_serial_clock_rise; // Host clock rose this cycle
	logic conv_serial_clock_fall; // Host clock fell this cycle

	// No internal conversion clock: every step waits for a host edge
	assign conv_serial_clock_rise = conv_serial_clock & ~conv_serial_clock_q;
	assign conv_serial_clock_fall = ~conv_serial_clock & conv_serial_clock_q;

	// ----------------------------------------------------------------
	// Frame controller state
	// ----------------------------------------------------------------
	touch_adc_pkg::frame_state_e state_q, state_d;
	logic [3:0] cnt_q, cnt_d; // Edge count within the current phase
	logic [6:0] shift_q, shift_d; // Incoming command bits
	logic [6:0] cmd_q, cmd_d; // Latched command
	logic [6:0] cmd_next; // Shift register with the current input bit
	logic [11:0] sar_q, sar_d; // Successive approximation register
	logic [11:0] result_q, result_d; // Last finished code
	logic rvalid_q, rvalid_d; // One-cycle result strobe
	logic dec_bit_q, dec_bit_d; // Last decided bit
	logic pend_q, pend_d; // Decided bit still to be shifted out
	logic out_q, out_d; // Serial output bit
	logic busy_q, busy_d; // Conversion busy flag
	logic ref_on_q, ref_on_d; // Internal reference enable
	logic [3:0] idx; // Bit under decision

	assign cmd_next = {shift_q[5:0], serial_in};

	// Next-state logic of the frame controller
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		cmd_d = cmd_q;
		sar_d = sar_q;
		result_d = result_q;
		rvalid_d = 1'b0;
		dec_bit_d = dec_bit_q;
		pend_d = pend_q;
		out_d = out_q;
		busy_d = busy_q;
		ref_on_d = ref_on_q;
		idx = 4'hB - cnt_q;
		if (chip_sel_n) begin
			// Deselect aborts any frame; the latched command survives
			state_d = touch_adc_pkg::ST_IDLE;
			cnt_d = 4'h0;
			pend_d = 1'b0;
			out_d = 1'b0;
			busy_d = 1'b0;
		end else if (conv_serial_clock_rise) begin
			case (state_q)
				touch_adc_pkg::ST_IDLE, touch_adc_pkg::ST_TAIL: begin
					// A high bit starts a command, also overlapping a tail
					if (serial_in) begin
						state_d = touch_adc_pkg::ST_CMD;
						cnt_d = 4'h0;
					end
				end
				touch_adc_pkg::ST_CMD: begin
					shift_d = cmd_next;
					if (cnt_q == touch_adc_pkg::CMD_BITS - 4'h1) begin
						cmd_d = cmd_next;
						ref_on_d = cmd_next[touch_adc_pkg::CMD_PD1];
						state_d = touch_adc_pkg::ST_ACQ;
						cnt_d = 4'h0;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
				touch_adc_pkg::ST_ACQ: begin
					if (cnt_q == touch_adc_pkg::ACQ_LEN - 4'h1) begin
						state_d = touch_adc_pkg::ST_CONV;
						cnt_d = 4'h0;
						sar_d = touch_adc_pkg::SAR_MSB;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
				touch_adc_pkg::ST_CONV: begin
					// Keep the trial bit when the input is at or above it
					sar_d[idx] = cmp_high;
					dec_bit_d = cmp_high;
					pend_d = 1'b1;
					if (cnt_q == res_len(cmd_q[touch_adc_pkg::CMD_MODE8]) - 4'h1) begin
						state_d = touch_adc_pkg::ST_TAIL;
						result_d = sar_d; // Straight binary, no offset
						rvalid_d = 1'b1;
					end else begin
						sar_d[idx - 4'h1] = 1'b1;
						cnt_d = cnt_q + 4'h1;
					end
				end
				default: begin
					state_d = touch_adc_pkg::ST_IDLE;
				end
			endcase
		end else if (conv_serial_clock_fall) begin
			// Busy covers acquisition up to the first data bit
			busy_d = (state_q == touch_adc_pkg::ST_ACQ) || (state_q == touch_adc_pkg::ST_CONV && !pend_q);
			out_d = pend_q & dec_bit_q;
			pend_d = 1'b0;
		end
	end

	// Registers of the frame controller; clk_en freezes everything
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conv_serial_clock_q <= 1'b0;
			state_q <= touch_adc_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= touch_adc_pkg::CMD_RST;
			cmd_q <= touch_adc_pkg::CMD_RST;
			sar_q <= touch_adc_pkg::CODE_RST;
			result_q <= touch_adc_pkg::CODE_RST;
			rvalid_q <= 1'b0;
			dec_bit_q <= 1'b0;
			pend_q <= 1'b0;
			out_q <= 1'b0;
			busy_q <= 1'b0;
			ref_on_q <= touch_adc_pkg::REF_ON_RST;
		end else if (clk_en) begin
			conv_serial_clock_q <= conv_serial_clock;
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			cmd_q <= cmd_d;
			sar_q <= sar_d;
			result_q <= result_d;
			rvalid_q <= rvalid_d;
			dec_bit_q <= dec_bit_d;
			pend_q <= pend_d;
			out_q <= out_d;
			busy_q <= busy_d;
			ref_on_q <= ref_on_d;
		end
	end

	// ----------------------------------------------------------------
	// Routing and power outputs
	// ----------------------------------------------------------------
	logic drv_en; // Panel drivers allowed on
	logic acq; // Acquisition phase in progress
	logic xp_w, xm_w, yp_w, ym_w, dlo_w, dhi_w, bat_w; // Decoder results
	logic [2:0] mux_w, rpos_w, rneg_w; // Decoder routing codes
	logic [17:0] route_q, route_d; // Registered routing bundle
	logic oe_q, oe_d; // Pin drive enable
	logic pwr_q, pwr_d; // Converter powered

	// Drivers stay on between conversions when the power bit is set
	assign drv_en = (state_q == touch_adc_pkg::ST_ACQ) || (state_q == touch_adc_pkg::ST_CONV)
		|| cmd_q[touch_adc_pkg::CMD_PD0];
	assign acq = (state_q == touch_adc_pkg::ST_ACQ);

	// Decoder reads only the latched command
	mux_route_decode u_decode (
		.sel(cmd_q[touch_adc_pkg::CMD_SEL_MSB:touch_adc_pkg::CMD_SEL_LSB]),
		.single_ended(cmd_q[touch_adc_pkg::CMD_SER]),
		.drv_en(drv_en),
		.acq(acq),
		.xp_on(xp_w),
		.xm_on(xm_w),
		.yp_on(yp_w),
		.ym_on(ym_w),
		.mux_in(mux_w),
		.ref_pos(rpos_w),
		.ref_neg(rneg_w),
		.diode_lo(dlo_w),
		.diode_hi(dhi_w),
		.bat_div(bat_w)
	);

	// Next values of the pin-facing outputs
	always_comb begin
		route_d = {xp_w, xm_w, yp_w, ym_w, mux_w, rpos_w, rneg_w, dlo_w, dhi_w, bat_w, acq,
			cmd_q[touch_adc_pkg::CMD_SER]};
		oe_d = !chip_sel_n;
		// Deselect powers the converter down; the power bit keeps it up between frames
		pwr_d = !chip_sel_n && ((state_d != touch_adc_pkg::ST_IDLE && state_d != touch_adc_pkg::ST_TAIL)
			|| cmd_d[touch_adc_pkg::CMD_PD0]);
	end

	// Output registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			route_q <= 18'h00000;
			oe_q <= 1'b0;
			pwr_q <= 1'b0;
		end else if (clk_en) begin
			route_q <= route_d;
			oe_q <= oe_d;
			pwr_q <= pwr_d;
		end
	end

	assign {xp_drv_on, xm_drv_on, yp_drv_on, ym_drv_on} = route_q[17:14];
	assign mux_in_sel = route_q[13:11];
	assign ref_pos_sel = route_q[10:8];
	assign ref_neg_sel = route_q[7:5];
	assign {diode_low_current, diode_high_current, battery_divider_on} = route_q[4:2];
	assign sample_hold = route_q[1];
	assign ref_mode_single_ended = route_q[0];
	assign serial_out = out_q;
	assign conv_busy = busy_q;
	assign serial_out_oe = oe_q;
	assign conv_busy_oe = oe_q;
	assign internal_ref_on = ref_on_q;
	assign adc_powered = pwr_q;
	assign dac_trial = sar_q;
	assign result_code = result_q;
	assign result_valid = rvalid_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [4:0] rise_cnt_q; // Rising edges since the start bit
	logic latch_cmd; // Command latched on this edge

	assign latch_cmd = clk_en && !chip_sel_n && conv_serial_clock_rise && state_q == touch_adc_pkg::ST_CMD
		&& cnt_q == touch_adc_pkg::CMD_BITS - 4'h1;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rise_cnt_q <= 5'h00;
		end else if (clk_en && conv_serial_clock_rise) begin
			rise_cnt_q <= (state_q == touch_adc_pkg::ST_IDLE || state_q == touch_adc_pkg::ST_TAIL) ?
				5'h01 : rise_cnt_q + 5'h01;
		end
	end

	sequence s_last_decision;
		clk_en && !chip_sel_n && conv_serial_clock_rise && state_q == touch_adc_pkg::ST_CONV
			&& state_d == touch_adc_pkg::ST_TAIL && !cmd_q[touch_adc_pkg::CMD_MODE8];
	endsequence

	a_out_falling_only: assert property (@(posedge clk) disable iff (sys_rst)
		!conv_serial_clock_fall && !chip_sel_n |=> $stable(serial_out)) else $error("serial output moved off a falling edge");
	a_pins_float_cs: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && chip_sel_n |=> !serial_out_oe && !conv_busy_oe) else $error("pins driven while deselected");
	a_cmd_capture: assert property (@(posedge clk) disable iff (sys_rst)
		latch_cmd |=> cmd_q == $past(cmd_next)) else $error("command not captured on rising edge");
	a_deselect_power: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && chip_sel_n |=> !adc_powered && state_q == touch_adc_pkg::ST_IDLE) else $error("converter up while deselected");
	a_ref_follow_bit: assert property (@(posedge clk) disable iff (sys_rst)
		latch_cmd |=> internal_ref_on == $past(shift_q[0])) else $error("reference enable not from command");
	a_frame_rise_count: assert property (@(posedge clk) disable iff (sys_rst)
		s_last_decision |=> rise_cnt_q == 5'(touch_adc_pkg::CMD_BITS) + 5'(touch_adc_pkg::ACQ_LEN)
			+ 5'(touch_adc_pkg::RES_FULL) + 5'h01) else $error("12-bit conversion not done at edge 23");
	a_diode_acq_only: assert property (@(posedge clk) disable iff (sys_rst)
		diode_low_current || diode_high_current |-> $past(state_q) == touch_adc_pkg::ST_ACQ) else $error("diode bias outside acquisition");
	a_cfg_held_conv: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_q == touch_adc_pkg::ST_CONV |=> $stable(cmd_q) && $stable(mux_in_sel)) else $error("routing changed in conversion");
	a_se_drivers_off: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == touch_adc_pkg::ST_CONV && cmd_q[touch_adc_pkg::CMD_SER] && cmd_q[5] == 1'b1 && cmd_q[4] == 1'b0
		|-> !(xp_drv_on || xm_drv_on || yp_drv_on || ym_drv_on)) else $error("drivers on for internal channel");
	a_se_x_route: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == touch_adc_pkg::ST_CONV && cmd_q[6:4] == touch_adc_pkg::SEL_X_POS
		|-> xp_drv_on && xm_drv_on && !yp_drv_on && mux_in_sel == touch_adc_pkg::IN_YP) else $error("X measurement misrouted");
	a_diff_y_refs: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == touch_adc_pkg::ST_CONV && !cmd_q[touch_adc_pkg::CMD_SER] && cmd_q[6:4] == touch_adc_pkg::SEL_Y_POS
		|-> ref_pos_sel == touch_adc_pkg::REF_YP && ref_neg_sel == touch_adc_pkg::REF_YN) else $error("differential Y references wrong");

endmodule

`default_nettype wire

//--- testbench/serial_host.sv
// Host serial master model driving the converter command link
`timescale 1ns/1ns
`default_nettype none

module serial_host (
	input wire logic clk,
	input wire logic sdo,
	output var logic sclk,
	output var logic cs_n,
	output var logic sdi,
	output var logic [4:0] rise_n
);
	// ----------------------------------------------------------------
	// Idle levels: deselected, clock parked low
	// ----------------------------------------------------------------
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		rise_n = 5'h00;
	end

	// One frame: start bit, command, then clocks only; the host clock alone
	// steps the conversion, so a short frame is simply an abort
	task automatic frame(input logic [6:0] cmd, input int div, input int n_rise, output logic [11:0] rd);
		logic [7:0] sh;
		int i;
		sh = {1'b1, cmd};
		rd = 12'h000;
		@(posedge clk);
		cs_n <= 1'b0;
		sdi <= sh[7];
		for (i = 1; i <= n_rise; i++) begin
			repeat (div) @(posedge clk);
			// Read the bit set up after the previous fall
			if (i >= 13) begin
				rd = {rd[10:0], sdo};
			end
			sclk <= 1'b1;
			rise_n <= i[4:0];
			repeat (div) @(posedge clk);
			sclk <= 1'b0;
			// New data only after the fall, stable over the next rise
			// Junk after the command, but never a start bit on rise 24
			sdi <= (i < 8) ? sh[7 - i] : ((i < 23) ? ~sdi : 1'b0);
		end
		repeat (div) @(posedge clk);
		cs_n <= 1'b1;
		sdi <= ~sdi;
		rise_n <= 5'h00;
	endtask
endmodule
`default_nettype wire

//--- testbench/test_touch_adc_channel_select.sv
// Self-checking bench of the touch converter control block
`timescale 1ns/1ns
`default_nettype none

module test_touch_adc_channel_select;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic clk, sys_rst, clk_en, cmp_high;
	wire logic sclk, cs_n, sdi, sdo_pin;
	wire logic [4:0] rise_n;
	logic serial_out, serial_out_oe, conv_busy, conv_busy_oe;
	logic xp_drv_on, xm_drv_on, yp_drv_on, ym_drv_on;
	logic [2:0] mux_in_sel, ref_pos_sel, ref_neg_sel;
	logic ref_mode_single_ended, internal_ref_on, adc_powered, sample_hold;
	logic diode_low_current, diode_high_current, battery_divider_on, result_valid;
	logic [11:0] dac_trial, result_code, vin, got_code, rd;
	logic [12:0] got_route;
	logic [3:0] got_bias;
	logic [15:0] lf;
	int fails, n_tests, nvalid, cyc, k;

	touch_adc_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .conv_serial_clock(sclk),
		.chip_sel_n(cs_n), .serial_in(sdi), .cmp_high(cmp_high), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .conv_busy(conv_busy), .conv_busy_oe(conv_busy_oe),
		.xp_drv_on(xp_drv_on), .xm_drv_on(xm_drv_on), .yp_drv_on(yp_drv_on), .ym_drv_on(ym_drv_on),
		.mux_in_sel(mux_in_sel), .ref_pos_sel(ref_pos_sel), .ref_neg_sel(ref_neg_sel),
		.ref_mode_single_ended(ref_mode_single_ended), .internal_ref_on(internal_ref_on),
		.adc_powered(adc_powered), .sample_hold(sample_hold), .diode_low_current(diode_low_current),
		.diode_high_current(diode_high_current), .battery_divider_on(battery_divider_on),
		.dac_trial(dac_trial), .result_code(result_code), .result_valid(result_valid));

	// Data pin floats while deselected; the host only reads it when selected
	assign sdo_pin = serial_out_oe ? serial_out : 1'bz;

	serial_host i_host (.clk(clk), .sdo(sdo_pin), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .rise_n(rise_n));

	// ----------------------------------------------------------------
	// Clock, ideal comparator, result capture, hang guard
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Analog core stand-in: ideal comparator against the trial code
	always @(posedge clk) begin
		cmp_high <= (vin >= dac_trial);
	end

	// Snapshot routing and bias loads when a result is delivered
	always @(posedge clk) begin
		cyc++;
		if (result_valid === 1'b1) begin
			nvalid++;
			got_code = result_code;
			got_route = {xp_drv_on, xm_drv_on, yp_drv_on, ym_drv_on, mux_in_sel, ref_pos_sel, ref_neg_sel};
			got_bias = {sample_hold, diode_low_current, diode_high_current, battery_divider_on};
		end
		if (cyc == 40000) begin
			fails++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Reference model and helpers
	// ----------------------------------------------------------------
	// Next state of the stimulus shift register
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Expected {xp, xm, yp, ym, input, +ref, -ref} for a selector
	function automatic logic [12:0] route(input logic [2:0] s, input logic se);
		logic [3:0] d;
		logic [2:0] m, p, n;
		d = (s == 3'h1) ? 4'h3 : ((s == 3'h3 || s == 3'h4) ? 4'h6 : ((s == 3'h5) ? 4'hC : 4'h0));
		case (s)
			3'h0, 3'h7: m = 3'h0;
			3'h1, 3'h3: m = 3'h1;
			3'h2: m = 3'h2;
			3'h4: m = 3'h3;
			3'h5: m = 3'h4;
			default: m = 3'h5;
		endcase
		p = 3'h0;
		n = 3'h1;
		// Ratiometric references come from the driven plate pins
		if (!se && d != 4'h0) begin
			p = (s == 3'h5) ? 3'h4 : 3'h2;
			n = (s == 3'h1) ? 3'h3 : 3'h5;
		end
		return {d, m, p, n};
	endfunction

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One command frame with all checks; n_rise below 19 aborts it in either resolution
	task automatic run(input logic [2:0] s, input logic se, input int n_rise);
		logic [6:0] cmd;
		logic [12:0] r;
		logic [11:0] exp;
		int div;
		lf = lfsr(lf);
		cmd = {s, lf[0], se, lf[1], lf[2]};
		vin = lf[15:4];
		div = 3 + int'(lf[3]) + int'(lf[4]);
		r = route(s, se);
		exp = cmd[3] ? {vin[11:4], 4'h0} : vin;
		nvalid = 0;
		fork
			i_host.frame(cmd, div, n_rise, rd);
			if (n_rise == 24) begin
				wait (rise_n == 5'h0A);
				repeat (3) @(negedge clk);
				chk("route acq", {3'h0, r}, {3'h0, xp_drv_on, xm_drv_on, yp_drv_on, ym_drv_on, mux_in_sel,
					ref_pos_sel, ref_neg_sel});
				chk("bias acq", {12'h000, 1'b1, s == 3'h0, s == 3'h7, s == 3'h2}, {12'h000, sample_hold,
					diode_low_current, diode_high_current, battery_divider_on});
				chk("busy acq", 16'h0003, {14'h0000, conv_busy, adc_powered});
				wait (rise_n == 5'h18);
				repeat (3) @(negedge clk);
				// Drivers stay on in the tail only when kept powered; busy long gone
				chk("drivers tail", {11'h000, cmd[0] ? r[12:9] : 4'h0, 1'b0}, {11'h000, xp_drv_on, xm_drv_on,
					yp_drv_on, ym_drv_on, conv_busy});
			end
		join
		repeat (3) @(negedge clk);
		chk("pins released", 16'h0000, {13'h0000, serial_out_oe, conv_busy_oe, adc_powered});
		chk("ref enable", {14'h0000, cmd[1], cmd[2]}, {14'h0000, internal_ref_on, ref_mode_single_ended});
		if (n_rise == 24) begin
			chk("result count", 16'h0001, nvalid[15:0]);
			chk("result code", {4'h0, exp}, {4'h0, got_code});
			chk("serial data", {4'h0, exp}, {4'h0, rd});
			chk("route conv", {3'h0, r}, {3'h0, got_route});
			chk("bias conv", 16'h0000, {12'h000, got_bias});
		end else begin
			chk("aborted result", 16'h0000, nvalid[15:0]);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		vin = 12'h000;
		lf = 16'h7FFE;
		fails = 0;
		n_tests = 0;
		cyc = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(negedge clk);
		chk("reset state", 16'h0000, {12'h000, internal_ref_on, serial_out_oe, conv_busy_oe, adc_powered});
		// First step from the seed leaves the reference bit clear
		run(3'h2, 1'b1, 24);
		// Every selector in both reference modes
		for (k = 0; k < 16; k++) begin
			run(k[2:0], k[3], 24);
		end
		// Deselect in mid-acquisition, then a clean frame must follow
		run(3'h5, 1'b0, 10);
		run(3'h1, 1'b0, 24);
		close_out();
	end
endmodule
`default_nettype wire
